// >>> rpe_pkg.sv
// constants and types shared by the radio protocol engine timing block
package rpe_pkg;
	// clock and time figures
	localparam int CLK_MHZ          = 25;
	localparam int SETUP_US         = 210;
	localparam int SETUP_CYC        = SETUP_US * CLK_MHZ;
	localparam int ACK_TIMEOUT_US   = 130;
	localparam int ACK_TIMEOUT_CYC  = ACK_TIMEOUT_US * CLK_MHZ;
	localparam int ARD_STEP_US      = 256;
	localparam int ARD_STEP_CYC     = ARD_STEP_US * CLK_MHZ;
	localparam int IRQ_LATENCY_US   = 3;
	localparam int IRQ_LATENCY_CYC  = IRQ_LATENCY_US * CLK_MHZ;
	localparam int TMR_W            = 17;
	localparam int DW               = 8;
	localparam int AW               = 8;

	// register byte offsets
	localparam logic [AW-1:0] ADDR_CTRL    = 8'h00;
	localparam logic [AW-1:0] ADDR_RETR    = 8'h04;
	localparam logic [AW-1:0] ADDR_TIMEOUT = 8'h08;
	localparam logic [AW-1:0] ADDR_STATUS  = 8'h0C;
	localparam logic [AW-1:0] ADDR_MASK    = 8'h10;
	localparam logic [AW-1:0] ADDR_OBSERVE = 8'h14;

	// field positions
	localparam int CTRL_PRX_BIT   = 0;
	localparam int RETR_LIM_LSB   = 0;
	localparam int RETR_ARD_LSB   = 4;
	localparam int IRQ_RX_DATA_READY_IRQ_BIT  = 0;
	localparam int IRQ_TX_DONE_IRQ_BIT  = 1;
	localparam int IRQ_RETRY_LIMIT_IRQ_BIT = 2;

	// reset values
	localparam logic [DW-1:0] RST_CTRL    = 8'h00;
	localparam logic [DW-1:0] RST_RETR    = 8'h13;
	localparam logic [DW-1:0] RST_TIMEOUT = 8'h82;
	localparam logic [2:0]    RST_MASK    = 3'h7;

	// engine states
	typedef enum logic [3:0] {
		RPE_IDLE, RPE_PTX_SETUP, RPE_PTX_TX, RPE_PTX_ACKW,
		RPE_PTX_ACKRX, RPE_PTX_ARD, RPE_PTX_HALT,
		RPE_PRX_RX, RPE_PRX_ACK
	} rpe_state_t;
endpackage : rpe_pkg

// >>> rpe_timer.sv
// one-shot down counter used for setup, timeout and retransmit delay
`timescale 1ns/1ps
module rpe_timer (
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    load_i,
	input  wire logic [rpe_pkg::TMR_W-1:0] value_i,
	output logic                         done_o
);
	import rpe_pkg::*;

	logic [TMR_W-1:0] cnt;
	logic             running;

	// count down, one pulse at expiry, a new load restarts
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnt     <= '0;
			running <= 1'b0;
			done_o  <= 1'b0;
		end else if (load_i) begin
			cnt     <= value_i;
			running <= 1'b1;
			done_o  <= 1'b0;
		end else if (running && cnt <= TMR_W'(1)) begin
			running <= 1'b0;
			done_o  <= 1'b1;
		end else begin
			cnt    <= running ? cnt - TMR_W'(1) : cnt;
			done_o <= 1'b0;
		end
	end
endmodule : rpe_timer

// >>> rpe_engine.sv
// protocol engine sequencing: transmitter and receiver timing with irqs
// Operation
// - every autonomous sequence except receiving a duplicate packet ends by raising the radio interrupt
// - activate high on receiver enters receive mode searching packets
// - transmit starts 210 us after activation, lasts the time on air
// - after sending with ack expected, switch to receive for the ack
// - receiver raises data ready on new packet, then sends an ack
// - ack received: raise tx done and remove packet from queue
// - interrupt asserts 3 us after its triggering event
// - ack wait times out after 130 us or shorter, then delay
// - retransmit delay is 0 us or 256 us steps up to 3840 us
// - no ack within setup, timeout and delay slot: resend packet
// - address match during ack wait holds receive until packet ends
// - ack carrying payload raises both tx done and data ready
// - receiver tx done for ack payload waits for next new packet
// - duplicate packet is acknowledged but raises no data ready
// - retry limit exceeded: raise retry irq, keep payload queued
// - retransmit delay setting counts in 256 us increments
`timescale 1ns/1ps
module rpe_engine #(
	parameter int SETUP_CYCLES    = rpe_pkg::SETUP_CYC,
	parameter int ARD_STEP_CYCLES = rpe_pkg::ARD_STEP_CYC
) (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	input  wire logic [rpe_pkg::AW-1:0] addr_i,
	input  wire logic [rpe_pkg::DW-1:0] wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [rpe_pkg::DW-1:0] rdata_o,
	input  wire logic                  activate_i,
	input  wire logic                  txq_not_empty_i,
	input  wire logic                  txq_no_ack_i,
	input  wire logic                  tx_air_done_i,
	input  wire logic                  addr_match_i,
	input  wire logic                  pkt_rx_done_i,
	input  wire logic                  pkt_rx_fail_i,
	input  wire logic [1:0]            pkt_rx_pid_i,
	input  wire logic                  pkt_rx_payload_i,
	input  wire logic                  pkt_no_ack_i,
	output logic                       tx_start_o,
	output logic                       tx_is_ack_o,
	output logic                       tx_on_o,
	output logic                       rx_on_o,
	output logic                       txq_pop_o,
	output logic      [1:0]            packet_sequence_id_o,
	output logic                       radio_interrupt_o
);
	import rpe_pkg::*;

	rpe_state_t       state;
	logic [DW-1:0]    ctrl;
	logic [DW-1:0]    retr;
	logic [DW-1:0]    ack_wait_timeout;
	logic [2:0]       status;
	logic [2:0]       mask;
	logic [2:0]       evt;
	logic [2:0]       pend;
	logic [6:0]       lat_cnt;
	logic             lat_run;
	logic [3:0]       retry_cnt;
	logic [1:0]       last_pid;
	logic             have_last;
	logic             ack_pl_sent;
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_val;
	logic             tmr_done;
	logic [3:0]       retransmit_delay;
	logic [3:0]       retry_limit_count;
	logic             primary_receiver;
	logic             rx_new;
	logic [TMR_W-1:0] timeout_cyc;
	logic [TMR_W-1:0] ard_cyc;
	logic [2:0]       status_set;

	assign retransmit_delay  = retr[RETR_ARD_LSB +: 4];
	assign retry_limit_count = retr[RETR_LIM_LSB +: 4];
	assign primary_receiver  = ctrl[CTRL_PRX_BIT];
	assign rx_new = !(have_last && pkt_rx_pid_i == last_pid);

	// word decode shared by read and write paths
	function automatic logic hit(input logic [AW-1:0] a,
			input logic [AW-1:0] r);
		hit = (a == r);
	endfunction : hit

	// timeout in cycles, clamped to the longest wait
	always_comb begin
		timeout_cyc = TMR_W'(ack_wait_timeout) * TMR_W'(CLK_MHZ);
		if (ack_wait_timeout > DW'(ACK_TIMEOUT_US))
			timeout_cyc = TMR_W'(ACK_TIMEOUT_CYC);
		ard_cyc = TMR_W'(retransmit_delay) * TMR_W'(ARD_STEP_CYCLES);
	end

	rpe_timer u_timer (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.load_i    (tmr_load),
		.value_i   (tmr_val),
		.done_o    (tmr_done)
	);

	// configuration registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl             <= RST_CTRL;
			retr             <= RST_RETR;
			ack_wait_timeout <= RST_TIMEOUT;
			mask             <= RST_MASK;
		end else if (wr_i) begin
			if (hit(addr_i, ADDR_CTRL))
				ctrl <= wdata_i;
			if (hit(addr_i, ADDR_RETR))
				retr <= wdata_i;
			if (hit(addr_i, ADDR_TIMEOUT))
				ack_wait_timeout <= wdata_i;
			if (hit(addr_i, ADDR_MASK))
				mask <= wdata_i[2:0];
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			if (hit(addr_i, ADDR_CTRL))
				rdata_o <= ctrl;
			else if (hit(addr_i, ADDR_RETR))
				rdata_o <= retr;
			else if (hit(addr_i, ADDR_TIMEOUT))
				rdata_o <= ack_wait_timeout;
			else if (hit(addr_i, ADDR_STATUS))
				rdata_o <= {5'h00, status};
			else if (hit(addr_i, ADDR_MASK))
				rdata_o <= {5'h00, mask};
			else if (hit(addr_i, ADDR_OBSERVE))
				rdata_o <= {DW'(state)} << 4 | {4'h0, retry_cnt};
			else
				rdata_o <= '0;
		end else begin
			rdata_o <= '0;
		end
	end

	// latency stage: events wait 3 us before reaching status
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pend    <= '0;
			lat_cnt <= '0;
			lat_run <= 1'b0;
		end else if (lat_run && lat_cnt == 7'h01) begin
			pend    <= evt;
			lat_run <= |evt;
			lat_cnt <= 7'(IRQ_LATENCY_CYC);
		end else begin
			pend    <= pend | evt;
			lat_run <= lat_run | (|evt);
			if (lat_run)
				lat_cnt <= lat_cnt - 7'h01;
			else
				lat_cnt <= 7'(IRQ_LATENCY_CYC);
		end
	end

	assign status_set = (lat_run && lat_cnt == 7'h01) ? pend : 3'h0;

	// sticky status, write one to clear, a new set wins
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			status <= '0;
		else if (wr_i && hit(addr_i, ADDR_STATUS))
			status <= (status & ~wdata_i[2:0]) | status_set;
		else
			status <= status | status_set;
	end

	// level interrupt toward the host
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			radio_interrupt_o <= 1'b0;
		else
			radio_interrupt_o <= |(status & mask);
	end

	// protocol sequencer
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state       <= RPE_IDLE;
			evt         <= '0;
			tmr_load    <= 1'b0;
			tmr_val     <= '0;
			tx_start_o  <= 1'b0;
			tx_is_ack_o <= 1'b0;
			tx_on_o     <= 1'b0;
			rx_on_o     <= 1'b0;
			txq_pop_o   <= 1'b0;
			retry_cnt   <= '0;
			last_pid    <= '0;
			have_last   <= 1'b0;
			ack_pl_sent <= 1'b0;
			packet_sequence_id_o <= '0;
		end else begin
			evt        <= '0;
			tmr_load   <= 1'b0;
			tx_start_o <= 1'b0;
			txq_pop_o  <= 1'b0;
			case (state)
			RPE_IDLE: begin
				tx_on_o <= 1'b0;
				rx_on_o <= 1'b0;
				// no start beside a removal: the queue flag lags by a cycle
				if (activate_i && primary_receiver) begin
					state   <= RPE_PRX_RX;
					rx_on_o <= 1'b1;
				end else if (activate_i && txq_not_empty_i && !txq_pop_o) begin
					state     <= RPE_PTX_SETUP;
					retry_cnt <= '0;
					tmr_load  <= 1'b1;
					tmr_val   <= TMR_W'(SETUP_CYCLES);
				end
			end
			RPE_PTX_SETUP: begin
				if (tmr_done) begin
					state       <= RPE_PTX_TX;
					tx_start_o  <= 1'b1;
					tx_is_ack_o <= 1'b0;
					tx_on_o     <= 1'b1;
				end
			end
			RPE_PTX_TX: begin
				if (tx_air_done_i) begin
					tx_on_o <= 1'b0;
					if (txq_no_ack_i) begin
						evt[IRQ_TX_DONE_IRQ_BIT] <= 1'b1;
						txq_pop_o <= 1'b1;
						packet_sequence_id_o <= packet_sequence_id_o + 2'h1;
						state <= RPE_IDLE;
					end else begin
						state    <= RPE_PTX_ACKW;
						rx_on_o  <= 1'b1;
						tmr_load <= 1'b1;
						tmr_val  <= timeout_cyc;
					end
				end
			end
			RPE_PTX_ACKW: begin
				if (addr_match_i) begin
					state <= RPE_PTX_ACKRX;
				end else if (tmr_done) begin
					state    <= RPE_PTX_ARD;
					rx_on_o  <= 1'b0;
					tmr_load <= 1'b1;
					tmr_val  <= ard_cyc;
				end
			end
			RPE_PTX_ACKRX: begin
				if (pkt_rx_done_i) begin
					rx_on_o <= 1'b0;
					evt[IRQ_TX_DONE_IRQ_BIT] <= 1'b1;
					evt[IRQ_RX_DATA_READY_IRQ_BIT] <= pkt_rx_payload_i;
					txq_pop_o <= 1'b1;
					packet_sequence_id_o <= packet_sequence_id_o + 2'h1;
					state <= RPE_IDLE;
				end else if (pkt_rx_fail_i) begin
					state    <= RPE_PTX_ARD;
					rx_on_o  <= 1'b0;
					tmr_load <= 1'b1;
					tmr_val  <= ard_cyc;
				end
			end
			RPE_PTX_ARD: begin
				if (tmr_done) begin
					if (retry_cnt >= retry_limit_count) begin
						evt[IRQ_RETRY_LIMIT_IRQ_BIT] <= 1'b1;
						state <= RPE_PTX_HALT;
					end else begin
						retry_cnt <= retry_cnt + 4'h1;
						state     <= RPE_PTX_SETUP;
						tmr_load  <= 1'b1;
						tmr_val   <= TMR_W'(SETUP_CYCLES);
					end
				end
			end
			RPE_PTX_HALT: begin
				// payload stays queued until activate is toggled
				if (!activate_i)
					state <= RPE_IDLE;
			end
			RPE_PRX_RX: begin
				if (!activate_i) begin
					state   <= RPE_IDLE;
					rx_on_o <= 1'b0;
				end else if (pkt_rx_done_i) begin
					if (rx_new) begin
						evt[IRQ_RX_DATA_READY_IRQ_BIT] <= 1'b1;
						evt[IRQ_TX_DONE_IRQ_BIT] <= ack_pl_sent;
						txq_pop_o   <= ack_pl_sent;
						ack_pl_sent <= 1'b0;
						last_pid    <= pkt_rx_pid_i;
						have_last   <= 1'b1;
					end
					if (!pkt_no_ack_i) begin
						state       <= RPE_PRX_ACK;
						rx_on_o     <= 1'b0;
						tx_on_o     <= 1'b1;
						tx_start_o  <= 1'b1;
						tx_is_ack_o <= 1'b1;
						if (rx_new)
							ack_pl_sent <= txq_not_empty_i;
					end
				end
			end
			RPE_PRX_ACK: begin
				if (tx_air_done_i) begin
					tx_on_o <= 1'b0;
					rx_on_o <= 1'b1;
					state   <= RPE_PRX_RX;
				end
			end
			default: begin
				state <= RPE_IDLE;
			end
			endcase
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_irq_follows_status: assert property (
		|(status & mask) |=> radio_interrupt_o)
		else $error("interrupt not raised for unmasked status");

	a_prx_enter_rx: assert property (
		state == RPE_IDLE && activate_i && primary_receiver
		|=> state == RPE_PRX_RX ##0 rx_on_o)
		else $error("receiver did not enter receive mode");

	a_tx_after_setup: assert property (
		state == RPE_PTX_SETUP && tmr_done
		|=> tx_start_o && !tx_is_ack_o && tx_on_o)
		else $error("transmit did not start after setup");

	a_ack_wait_rx: assert property (
		state == RPE_PTX_TX && tx_air_done_i && !txq_no_ack_i
		|=> state == RPE_PTX_ACKW && rx_on_o && !tx_on_o)
		else $error("no switch to receive for ack");

	a_prx_new_ack: assert property (
		state == RPE_PRX_RX && activate_i && pkt_rx_done_i && rx_new
		&& !pkt_no_ack_i
		|=> evt[IRQ_RX_DATA_READY_IRQ_BIT] && tx_start_o && tx_is_ack_o)
		else $error("new packet not flagged and acknowledged");

	a_pop_with_done: assert property (
		state == RPE_PTX_ACKRX && pkt_rx_done_i
		|=> txq_pop_o && evt[IRQ_TX_DONE_IRQ_BIT])
		else $error("acked packet not removed");

	a_irq_latency: assert property (
		$rose(evt[IRQ_RETRY_LIMIT_IRQ_BIT]) && !lat_run
		|-> ##(75) status_set[IRQ_RETRY_LIMIT_IRQ_BIT])
		else $error("interrupt latency wrong");

	a_hold_on_match: assert property (
		state == RPE_PTX_ACKRX && !pkt_rx_done_i && !pkt_rx_fail_i
		|=> state == RPE_PTX_ACKRX && rx_on_o)
		else $error("left receive before packet end");

	a_ack_payload: assert property (
		state == RPE_PTX_ACKRX && pkt_rx_done_i && pkt_rx_payload_i
		|=> evt[IRQ_TX_DONE_IRQ_BIT] && evt[IRQ_RX_DATA_READY_IRQ_BIT])
		else $error("ack payload irqs missing");

	a_dup_quiet: assert property (
		state == RPE_PRX_RX && activate_i && pkt_rx_done_i && !rx_new
		&& !pkt_no_ack_i
		|=> !evt[IRQ_RX_DATA_READY_IRQ_BIT] && tx_start_o)
		else $error("duplicate packet mishandled");

	a_limit_keeps: assert property (
		state == RPE_PTX_ARD && tmr_done && retry_cnt >= retry_limit_count
		|=> evt[IRQ_RETRY_LIMIT_IRQ_BIT] && !txq_pop_o && state == RPE_PTX_HALT)
		else $error("retry limit handling wrong");
endmodule : rpe_engine

// >>> rpe_peer.sv
// peer engine and modem model facing the protocol engine
`timescale 1ns/1ps
module rpe_peer #(
	parameter int AIR = 30
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       tx_start_i,
	input  wire logic       rx_on_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       send_i,
	input  wire logic [1:0] pid_i,
	output logic            air_done_o,
	output logic            match_o,
	output logic            done_o,
	output logic [1:0]      pid_o,
	output logic            pay_o
);
	int   air_cnt;
	int   ack_cnt;
	logic rx_q;
	logic fin;

	// packet end: host-driven packet, or ack prompt or held past timeout
	assign fin = send_i || ack_cnt == (mode_i == 2'h3 ? 305 : 9);

	// time on air, then an ack on a fresh receive window
	always_ff @(posedge sys_clk_i) begin
		rx_q       <= rx_on_i;
		air_done_o <= (air_cnt == 1);
		match_o    <= (ack_cnt == 5);
		done_o     <= fin;
		pid_o      <= fin ? pid_i : ~pid_o; // idle lines never hold
		pay_o      <= fin ? (mode_i == 2'h2 && !send_i) : ~pay_o;
		if (rst_i) begin
			air_cnt <= 0;
			ack_cnt <= 0;
			pid_o   <= 2'h0;
			pay_o   <= 1'b0;
		end else begin
			air_cnt <= tx_start_i ? AIR : (air_cnt > 0 ? air_cnt - 1 : 0);
			if (!rx_on_i || ack_cnt > 305)
				ack_cnt <= 0;
			else if (ack_cnt > 0 || (!rx_q && mode_i != 2'h0))
				ack_cnt <= ack_cnt + 1;
		end
	end
endmodule : rpe_peer

// >>> testbench.sv
// self-checking bench for the protocol engine timing block
`timescale 1ns/1ps
module testbench;
	import rpe_pkg::*;
	logic       clk, rst, wr, rd, act, txq_ne, send, no_ack;
	logic [7:0] addr, wdata, rdata;
	logic       air_done, match, done, pay, tx_start, tx_is_ack;
	logic       tx_on, rx_on, pop, irq;
	logic [1:0] pid_in, pid_rx, pid_out, mode;
	int         err_total, compares, pops, n;

	rpe_engine #(
		.SETUP_CYCLES    (20),
		.ARD_STEP_CYCLES (16)
	) dut (
		.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .activate_i(act),
		.txq_not_empty_i(txq_ne), .txq_no_ack_i(no_ack),
		.tx_air_done_i(air_done), .addr_match_i(match),
		.pkt_rx_done_i(done), .pkt_rx_fail_i(1'b0), .pkt_rx_pid_i(pid_rx),
		.pkt_rx_payload_i(pay), .pkt_no_ack_i(1'b0), .tx_start_o(tx_start),
		.tx_is_ack_o(tx_is_ack), .tx_on_o(tx_on), .rx_on_o(rx_on),
		.txq_pop_o(pop), .packet_sequence_id_o(pid_out),
		.radio_interrupt_o(irq)
	);

	rpe_peer #(.AIR(30)) peer (
		.sys_clk_i(clk), .rst_i(rst), .tx_start_i(tx_start), .rx_on_i(rx_on),
		.mode_i(mode), .send_i(send), .pid_i(pid_in), .air_done_o(air_done),
		.match_o(match), .done_o(done), .pid_o(pid_rx), .pay_o(pay)
	);

	// clock
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// one-entry queue model, emptied by a removal
	always @(posedge clk) begin
		if (pop === 1'b1) begin
			pops++;
			txq_ne <= 1'b0;
		end
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic rng(input int v, input int lo, input int hi);
		chk({7'h00, v >= lo && v <= hi}, 8'h01);
	endtask : rng

	// bounded wait for a level, counting edges
	task automatic wt(ref logic s, input logic val, output int k);
		k = 0;
		while (s !== val && k < 3000) begin
			@(posedge clk);
			k++;
		end
	endtask : wt

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(posedge clk);
		chk(rdata, e);
	endtask : rd_chk

	task automatic ptx_go(input logic [1:0] m);
		mode   <= m;
		txq_ne <= 1'b1;
		act    <= 1'b1;
		wt(tx_start, 1'b1, n);
		rng(n, 20, 26);
		wt(rx_on, 1'b1, n);
		rng(n, 30, 34);
	endtask : ptx_go

	task automatic ptx_end;
		mode   <= 2'h0;
		txq_ne <= 1'b0;
		repeat (500) @(posedge clk);
		act <= 1'b0;
		repeat (5250) @(posedge clk);
	endtask : ptx_end

	task automatic t_reset;
		rd_chk(ADDR_RETR, RST_RETR);
		rd_chk(ADDR_TIMEOUT, RST_TIMEOUT);
		rd_chk(ADDR_MASK, {5'h00, RST_MASK});
		rd_chk(ADDR_STATUS, 8'h00);
		rd_chk(8'h18, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask : t_reset

	// prompt ack, ack with payload, ack held past the timeout
	task automatic t_ack;
		for (int m = 1; m < 4; m++) begin
			ptx_go(2'(m));
			wt(pop, 1'b1, n);
			if (m == 3)
				rng(n, 295, 310);
			else
				rng(n, 5, 14);
			wt(irq, 1'b1, n);
			rng(n, 70, 80);
			rd_chk(ADDR_STATUS, m == 2 ? 8'h03 : 8'h02);
			chk({6'h00, pid_out}, 8'(m));
			wr_reg(ADDR_STATUS, 8'h07);
			@(posedge clk);
			chk({7'h00, irq}, 8'h00);
			ptx_end();
		end
	endtask : t_ack

	task automatic t_mask;
		wr_reg(ADDR_MASK, 8'h00);
		ptx_go(2'h1);
		repeat (120) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		rd_chk(ADDR_STATUS, 8'h02);
		wr_reg(ADDR_MASK, 8'h07);
		@(posedge clk);
		chk({7'h00, irq}, 8'h01);
		wr_reg(ADDR_STATUS, 8'h07);
		ptx_end();
	endtask : t_mask

	// packet sent without ack: removed at once, no receive window
	task automatic t_noack;
		no_ack <= 1'b1;
		txq_ne <= 1'b1;
		act    <= 1'b1;
		wt(pop, 1'b1, n);
		rng(n, 50, 60);
		chk({7'h00, rx_on}, 8'h00);
		wt(irq, 1'b1, n);
		rng(n, 70, 80);
		rd_chk(ADDR_STATUS, 8'h02);
		wr_reg(ADDR_STATUS, 8'h07);
		no_ack <= 1'b0;
		ptx_end();
	endtask : t_noack

	// no ack: timeout, delay of 0, 1 and 15 steps, retry limit of one
	task automatic t_retry;
		int st[3] = '{0, 1, 15};
		int k;
		foreach (st[i]) begin
			wr_reg(ADDR_RETR, {4'(st[i]), 4'h1});
			k = pops;
			ptx_go(2'h0);
			wt(rx_on, 1'b0, n);
			rng(n, 195, 206);
			wt(tx_start, 1'b1, n);
			rng(n, 20 + 16 * st[i], 27 + 16 * st[i]);
			wt(irq, 1'b1, n);
			rd_chk(ADDR_STATUS, 8'h04);
			chk(8'(pops - k), 8'h00);
			wr_reg(ADDR_STATUS, 8'h07);
			ptx_end();
		end
	endtask : t_retry

	task automatic rx_pkt(input logic [1:0] p);
		wt(rx_on, 1'b1, n);
		pid_in <= p;
		send   <= 1'b1;
		@(posedge clk);
		send   <= 1'b0;
		wt(tx_start, 1'b1, n);
		rng(n, 1, 4);
		chk({7'h00, tx_is_ack}, 8'h01);
		repeat (90) @(posedge clk);
	endtask : rx_pkt

	task automatic t_prx;
		wr_reg(ADDR_CTRL, 8'h01);
		act <= 1'b1;
		wt(rx_on, 1'b1, n);
		rng(n, 1, 4);
		rx_pkt(2'h1);
		rd_chk(ADDR_STATUS, 8'h01);
		wr_reg(ADDR_STATUS, 8'h07);
		rx_pkt(2'h1);
		rd_chk(ADDR_STATUS, 8'h00);
		txq_ne <= 1'b1;
		rx_pkt(2'h2);
		rd_chk(ADDR_STATUS, 8'h01);
		wr_reg(ADDR_STATUS, 8'h07);
		rx_pkt(2'h3);
		rd_chk(ADDR_STATUS, 8'h03);
		chk({7'h00, txq_ne}, 8'h00);
		act <= 1'b0;
	endtask : t_prx

	task automatic wrap_up;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	// main sequence
	initial begin
		{rst, wr, rd, act, txq_ne, send} = 6'h20;
		addr = 8'h00;
		wdata = 8'h00;
		pid_in = 2'h0;
		mode = 2'h0;
		no_ack = 1'b0;
		err_total = 0;
		compares = 0;
		pops = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		wr_reg(ADDR_TIMEOUT, 8'h08);
		t_ack();
		t_mask();
		t_noack();
		t_retry();
		t_prx();
		wrap_up();
	end

	// watchdog
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		wrap_up();
	end
endmodule : testbench
